/* File: rtl/expander_pkg.sv */
// constants and types for the two-address serial port expander
// Summary of operation
// - device answers two slave addresses picked by two straps out of 32
// - address 101xxxx reads and writes push-pull outputs eight to fifteen
// - address 110xxxx serves outputs 0,1,6,7 and open-drain ports 2 to 5
// - serial slave works with bus clocks up to 400 kHz
// - reset returns the serial interface to idle, aborting any transfer
// - open-drain port written high is released and may serve as input
// - reads return sampled pin levels for open-drain ports 2 to 5, the written latches for push-pull outputs
// - reset input is active low and clears the two-wire interface
// - each strap decodes ground, supply, clock line or data line
// - sticky flags record any open-drain input change since last read of address 110xxxx
package expander_pkg;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          SCL_MAX_HZ    = 400_000;
    // shortest bus clock period in system cycles, rounded down
    localparam int          SCL_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ;
    localparam int          SYNC_LAT      = 3;
    localparam logic [2:0]  ADDR_UPPER    = 3'h5;
    localparam logic [2:0]  ADDR_LOWER    = 3'h6;
    localparam logic [1:0]  STRAP_GND     = 2'h0;
    localparam logic [1:0]  STRAP_VDD     = 2'h1;
    localparam logic [1:0]  STRAP_SCL     = 2'h2;
    localparam logic [1:0]  STRAP_SDA     = 2'h3;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  LAST_BIT      = 4'h7;
    localparam int          OD_LSB        = 2;
    localparam int          OD_MSB        = 5;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_DATA  = 3'h2,
        ST_WR_ACK   = 3'h6,
        ST_RD_DATA  = 3'h7,
        ST_RD_ACK   = 3'h5
    } bus_state_e;
endpackage

/* File: rtl/port_expander.sv */
// serial slave with two port groups, open-drain read-back and change flags
`timescale 1ns/1ns
module port_expander #(
    parameter logic [7:0] UPPER_RESET = 8'hff,
    parameter logic [3:0] LOWPP_RESET = 4'hf,
    parameter logic [3:0] OD_RESET    = 4'hf
) (
    input  wire logic       CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_OUT,
    input  wire logic       ADDR_STRAP_HI_IN,
    input  wire logic       ADDR_STRAP_LO_IN,
    output logic [7:0]      PUSHPULL_UPPER_GROUP_OUT,
    output logic            PUSHPULL_BIT_ZERO_OUT,
    output logic            PUSHPULL_BIT_ONE_OUT,
    output logic            PUSHPULL_BIT_SIX_OUT,
    output logic            PUSHPULL_BIT_SEVEN_OUT,
    input  wire logic [3:0] OPENDRAIN_IO_GROUP_IN,
    output logic [3:0]      OPENDRAIN_IO_GROUP_OUT,
    output logic [3:0]      OPENDRAIN_IO_GROUP_OE_OUT,
    output logic [3:0]      TRANSITION_FLAG_OUT
);
    typedef struct packed {
        logic [2:0]             scl_sync;
        logic [2:0]             sda_sync;
        logic [2:0][3:0]        od_sync;
        logic [2:0][1:0]        strap_sync;
        logic [2:0]             fill;
        logic                   scl_f;
        logic                   sda_f;
        logic [3:0]             od_f;
        logic [1:0]             seen_one;
        logic [1:0]             seen_zero;
        logic [1:0]             off_scl;
        logic [1:0]             off_sda;
        expander_pkg::bus_state_e state;
        logic [3:0]             cnt;
        logic [7:0]             sh;
        logic                   sel_low;
        logic                   sda_oe;
        logic                   sda_level;
        logic [7:0]             upper;
        logic [3:0]             lowpp;      // {o7, o6, o1, o0}
        logic [3:0]             od_oe;
        logic [3:0]             od_level;
        logic [3:0]             flags;
    } regs_s;

    localparam regs_s REGS_RESET = '{
        state:    expander_pkg::ST_IDLE,
        scl_f:    1'b1,
        sda_f:    1'b1,
        od_f:     4'hf,
        upper:    UPPER_RESET,
        lowpp:    LOWPP_RESET,
        od_oe:    ~OD_RESET,
        default:  '0
    };

    regs_s st;
    regs_s next_st;

    // straps tied to a bus line are told apart by watching which line
    // they follow; only samples where every line is settled count
    function automatic logic [1:0] strap_code(input logic one,
                                              input logic zero,
                                              input logic offc,
                                              input logic offd);
        if (!one)
            return expander_pkg::STRAP_GND;
        else if (!zero)
            return expander_pkg::STRAP_VDD;
        else if (!offc)
            return expander_pkg::STRAP_SCL;
        else
            return expander_pkg::STRAP_SDA;
    endfunction

    logic [3:0] code_nib;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       stable;
    logic [7:0] low_byte;

    always_comb begin
        next_st = st;
        code_nib = {strap_code(st.seen_one[1], st.seen_zero[1],
                               st.off_scl[1], st.off_sda[1]),
                    strap_code(st.seen_one[0], st.seen_zero[0],
                               st.off_scl[0], st.off_sda[0])};
        // read-back takes live pin levels for the open-drain ports
        low_byte = {st.lowpp[3:2], st.od_f, st.lowpp[1:0]};

        next_st.scl_sync = {st.scl_sync[1:0], SCL_IN};
        next_st.sda_sync = {st.sda_sync[1:0], SDA_IN};
        next_st.od_sync = {st.od_sync[1:0], OPENDRAIN_IO_GROUP_IN};
        next_st.strap_sync = {st.strap_sync[1:0],
                              ADDR_STRAP_HI_IN, ADDR_STRAP_LO_IN};
        // sync stages hold reset zeros, not pin samples, for three cycles
        next_st.fill = {st.fill[1:0], 1'b1};
        if (st.fill[2] && st.scl_sync[1] == st.scl_sync[2])
            next_st.scl_f = st.scl_sync[2];
        if (st.fill[2] && st.sda_sync[1] == st.sda_sync[2])
            next_st.sda_f = st.sda_sync[2];
        for (int i = 0; i < 4; i++) begin
            if (st.fill[2] && st.od_sync[1][i] == st.od_sync[2][i])
                next_st.od_f[i] = st.od_sync[2][i];
        end
        stable = st.fill[2] && (st.scl_sync[1] == st.scl_sync[2]) &&
                 (st.sda_sync[1] == st.sda_sync[2]) &&
                 (st.strap_sync[1] == st.strap_sync[2]);
        if (stable) begin
            for (int i = 0; i < 2; i++) begin
                next_st.seen_one[i] = st.seen_one[i] |
                                      st.strap_sync[2][i];
                next_st.seen_zero[i] = st.seen_zero[i] |
                                       ~st.strap_sync[2][i];
                next_st.off_scl[i] = st.off_scl[i] |
                    (st.strap_sync[2][i] ^ st.scl_sync[2]);
                next_st.off_sda[i] = st.off_sda[i] |
                    (st.strap_sync[2][i] ^ st.sda_sync[2]);
            end
        end

        scl_rise = next_st.scl_f & ~st.scl_f;
        scl_fall = ~next_st.scl_f & st.scl_f;
        start_c = st.scl_f & next_st.scl_f & st.sda_f & ~next_st.sda_f;
        stop_c = st.scl_f & next_st.scl_f & ~st.sda_f & next_st.sda_f;

        // transient changes latch; a change in the clearing cycle wins
        next_st.flags = st.flags | (st.od_f ^ next_st.od_f);

        if (start_c) begin
            next_st.state = expander_pkg::ST_ADDR;
            next_st.cnt = '0;
            next_st.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_st.state = expander_pkg::ST_IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            case (st.state)
                expander_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        next_st.sh = {st.sh[6:0], next_st.sda_f};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall &&
                                 st.cnt == expander_pkg::BYTE_BITS) begin
                        if (st.sh[7:1] == {expander_pkg::ADDR_UPPER,
                                           code_nib}) begin
                            next_st.sel_low = 1'b0;
                            next_st.sda_oe = 1'b1;
                            next_st.state = expander_pkg::ST_ADDR_ACK;
                        end else if (st.sh[7:1] ==
                                     {expander_pkg::ADDR_LOWER,
                                      code_nib}) begin
                            next_st.sel_low = 1'b1;
                            next_st.sda_oe = 1'b1;
                            next_st.state = expander_pkg::ST_ADDR_ACK;
                        end else begin
                            next_st.state = expander_pkg::ST_IDLE;
                        end
                    end
                end
                expander_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_st.cnt = '0;
                        if (st.sh[0]) begin
                            next_st.sh = st.sel_low ? low_byte : st.upper;
                            next_st.sda_oe = st.sel_low ? ~low_byte[7]
                                                        : ~st.upper[7];
                            next_st.state = expander_pkg::ST_RD_DATA;
                            if (st.sel_low)
                                next_st.flags = st.od_f ^ next_st.od_f;
                        end else begin
                            next_st.sda_oe = 1'b0;
                            next_st.state = expander_pkg::ST_WR_DATA;
                        end
                    end
                end
                expander_pkg::ST_WR_DATA: begin
                    if (scl_rise) begin
                        next_st.sh = {st.sh[6:0], next_st.sda_f};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall &&
                                 st.cnt == expander_pkg::BYTE_BITS) begin
                        // every byte goes straight to the latches
                        if (st.sel_low) begin
                            next_st.lowpp = {st.sh[7:6], st.sh[1:0]};
                            next_st.od_oe = ~st.sh[expander_pkg::OD_MSB:
                                                   expander_pkg::OD_LSB];
                        end else begin
                            next_st.upper = st.sh;
                        end
                        next_st.sda_oe = 1'b1;
                        next_st.state = expander_pkg::ST_WR_ACK;
                    end
                end
                expander_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.cnt = '0;
                        next_st.state = expander_pkg::ST_WR_DATA;
                    end
                end
                expander_pkg::ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (st.cnt == expander_pkg::LAST_BIT) begin
                            next_st.sda_oe = 1'b0;
                            next_st.state = expander_pkg::ST_RD_ACK;
                        end else begin
                            next_st.sh = {st.sh[6:0], 1'b0};
                            next_st.sda_oe = ~st.sh[6];
                            next_st.cnt = st.cnt + 4'h1;
                        end
                    end
                end
                expander_pkg::ST_RD_ACK: begin
                    if (scl_rise && next_st.sda_f) begin
                        next_st.state = expander_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        next_st.cnt = '0;
                        next_st.sh = st.sel_low ? low_byte : st.upper;
                        next_st.sda_oe = st.sel_low ? ~low_byte[7]
                                                    : ~st.upper[7];
                        next_st.state = expander_pkg::ST_RD_DATA;
                        if (st.sel_low)
                            next_st.flags = st.od_f ^ next_st.od_f;
                    end
                end
                default: begin
                    next_st.state = expander_pkg::ST_IDLE;
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // async clear drops any transfer mid-byte and frees the data line
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st <= REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign SDA_OUT = st.sda_level;
    assign SDA_OE_OUT = st.sda_oe;
    assign PUSHPULL_UPPER_GROUP_OUT = st.upper;
    assign PUSHPULL_BIT_ZERO_OUT = st.lowpp[0];
    assign PUSHPULL_BIT_ONE_OUT = st.lowpp[1];
    assign PUSHPULL_BIT_SIX_OUT = st.lowpp[2];
    assign PUSHPULL_BIT_SEVEN_OUT = st.lowpp[3];
    // ports only ever pull low; a high latch leaves the pin to the board
    assign OPENDRAIN_IO_GROUP_OUT = st.od_level;
    assign OPENDRAIN_IO_GROUP_OE_OUT = st.od_oe;
    assign TRANSITION_FLAG_OUT = st.flags;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence addr_byte_done;
        st.state == expander_pkg::ST_ADDR &&
        st.cnt == expander_pkg::BYTE_BITS && scl_fall && !start_c;
    endsequence

    addr_ack_match_a: assert property (
        addr_byte_done ##1 st.state == expander_pkg::ST_ADDR_ACK
        |-> st.sh[4:1] == code_nib && SDA_OE_OUT &&
            (st.sh[7:5] == (st.sel_low ? expander_pkg::ADDR_LOWER
                                       : expander_pkg::ADDR_UPPER)))
        else $error("acknowledged an address not set by the straps");

    upper_write_a: assert property (
        st.state == expander_pkg::ST_WR_DATA && scl_fall && !start_c &&
        !stop_c && st.cnt == expander_pkg::BYTE_BITS && !st.sel_low
        |=> PUSHPULL_UPPER_GROUP_OUT == $past(st.sh) && SDA_OE_OUT)
        else $error("upper group write not applied");

    lower_write_a: assert property (
        st.state == expander_pkg::ST_WR_DATA && scl_fall && !start_c &&
        !stop_c && st.cnt == expander_pkg::BYTE_BITS && st.sel_low
        |=> {PUSHPULL_BIT_SEVEN_OUT, PUSHPULL_BIT_SIX_OUT,
             PUSHPULL_BIT_ONE_OUT, PUSHPULL_BIT_ZERO_OUT} ==
            {$past(st.sh[7:6]), $past(st.sh[1:0])} &&
            OPENDRAIN_IO_GROUP_OE_OUT == ~$past(st.sh[5:2]))
        else $error("lower group write not applied");

    sda_low_phase_a: assert property (
        $rose(SDA_OE_OUT) |-> !st.scl_f)
        else $error("data line driven while clock high");

    // must stay armed while reset is low, so the default disable is off
    reset_idle_a: assert property (@(posedge CLK_IN)
        disable iff (1'b0)
        !RST_N_IN && $past(!RST_N_IN)
        |-> st.state == expander_pkg::ST_IDLE && !SDA_OE_OUT)
        else $error("reset left the serial interface busy");

    od_never_high_a: assert property (
        OPENDRAIN_IO_GROUP_OUT == 4'h0)
        else $error("open-drain port driven high");

    read_pins_a: assert property (
        st.state == expander_pkg::ST_ADDR_ACK && scl_fall && st.sh[0] &&
        st.sel_low && !start_c && !stop_c
        |=> st.sh[5:2] == $past(st.od_f))
        else $error("read did not sample the pin levels");

    flag_sticky_a: assert property (
        ((st.od_f ^ $past(st.od_f)) & ~st.flags) == 4'h0)
        else $error("open-drain change not flagged");

    byte_bound_a: assert property (
        st.cnt <= expander_pkg::BYTE_BITS)
        else $error("bit counter ran past one byte");
endmodule // port_expander

/* File: dv/i2c_master_model.sv */
// serial bus master model that clocks the expander through its bus pins
`timescale 1ns/1ns
module i2c_master_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // 30 low plus 20 high cycles of 50 ns give 2.5 us, 400 kHz per data bit; stop and repeated start rise after 20 low
    task automatic start_cond;
        sda_low_out = 1'b0;
        wait_cyc(10);
        scl_out = 1'b1;
        wait_cyc(20);
        sda_low_out = 1'b1;
        wait_cyc(15);
        scl_out = 1'b0;
        wait_cyc(10);
    endtask
    task automatic stop_cond;
        sda_low_out = 1'b1;
        wait_cyc(10);
        scl_out = 1'b1;
        wait_cyc(20);
        sda_low_out = 1'b0;
        wait_cyc(30);
    endtask
    // a one is sent by releasing the line, so the port stays an input
    task automatic send_bit(input logic b);
        sda_low_out = ~b;
        wait_cyc(20);
        scl_out = 1'b1;
        wait_cyc(20);
        scl_out = 1'b0;
        wait_cyc(10);
    endtask
    task automatic recv_bit(output logic b);
        sda_low_out = 1'b0;
        wait_cyc(20);
        scl_out = 1'b1;
        wait_cyc(10);
        b = sda_in;
        wait_cyc(10);
        scl_out = 1'b0;
        wait_cyc(10);
    endtask
    // one whole byte per transfer, most significant bit first
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
        recv_bit(b);
        ack = ~b;
    endtask
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            recv_bit(b);
            d[i] = b;
        end
        send_bit(last);
    endtask
endmodule // i2c_master_model

/* File: dv/i2c_port_expander_16_tb.sv */
// self-checking bench for the two-address serial port expander
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end end
module i2c_port_expander_16_tb;
    localparam logic [6:0] ADR_UP  = {expander_pkg::ADDR_UPPER,
        expander_pkg::STRAP_GND, expander_pkg::STRAP_SCL};
    localparam logic [6:0] ADR_LO  = {expander_pkg::ADDR_LOWER,
        expander_pkg::STRAP_GND, expander_pkg::STRAP_SCL};
    localparam logic [6:0] ADR_BAD = {expander_pkg::ADDR_LOWER,
        expander_pkg::STRAP_VDD, expander_pkg::STRAP_SCL};
    logic       clk, rst_n, strap_lvl, strap_sel, sda_out, sda_oe;
    logic       o0, o1, o6, o7;
    logic [7:0] upper;
    logic [3:0] ext_lvl, od_pin, od_out, od_oe, flags;
    wire        scl, sda_low, sda, strap_hi;
    int         fail_count, compares;
    // the data line and the ports have pull-ups on the board; the master drives the clock line directly
    assign sda    = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    assign od_pin = ext_lvl & (~od_oe | od_out);
    // upper strap is tied either to a fixed level or to the data line
    assign strap_hi = strap_sel ? sda : strap_lvl;
    i2c_master_model m (.clk_in(clk), .sda_in(sda), .scl_out(scl),
        .sda_low_out(sda_low));
    port_expander DUT (
        .CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
        .ADDR_STRAP_HI_IN(strap_hi), .ADDR_STRAP_LO_IN(scl),
        .PUSHPULL_UPPER_GROUP_OUT(upper), .PUSHPULL_BIT_ZERO_OUT(o0),
        .PUSHPULL_BIT_ONE_OUT(o1), .PUSHPULL_BIT_SIX_OUT(o6),
        .PUSHPULL_BIT_SEVEN_OUT(o7), .OPENDRAIN_IO_GROUP_IN(od_pin),
        .OPENDRAIN_IO_GROUP_OUT(od_out), .OPENDRAIN_IO_GROUP_OE_OUT(od_oe),
        .TRANSITION_FLAG_OUT(flags));
    always #25 clk = ~clk;
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic write_one(input logic [6:0] a, input logic [7:0] d,
                             output logic aa, output logic ad);
        m.start_cond;
        m.write_byte({a, 1'b0}, aa);
        ad = 1'b0;
        if (aa) m.write_byte(d, ad);
        m.stop_cond;
    endtask
    task automatic read_one(input logic [6:0] a, output logic [7:0] d);
        logic aa;
        m.start_cond;
        m.write_byte({a, 1'b1}, aa);
        d = 8'h00;
        if (aa) m.read_byte(1'b1, d);
        m.stop_cond;
    endtask
    task automatic reset_values;
        `CHK({upper, o0, o1, o6, o7}, 12'hfff)
        `CHK({od_oe, flags, sda_oe}, 9'h000)
    endtask
    task automatic upper_group;
        logic aa, ad;
        logic [7:0] d;
        write_one(ADR_UP, 8'ha5, aa, ad);
        `CHK({aa, ad}, 2'h3)
        `CHK(upper, 8'ha5)
        // write then read back across a repeated start
        m.start_cond;
        m.write_byte({ADR_UP, 1'b0}, aa);
        m.write_byte(8'h3c, ad);
        m.start_cond;
        m.write_byte({ADR_UP, 1'b1}, aa);
        m.read_byte(1'b1, d);
        m.stop_cond;
        `CHK(d, 8'h3c)
        `CHK({o0, o7, od_oe}, 6'h30)
    endtask
    task automatic lower_group;
        logic aa, ad;
        write_one(ADR_LO, 8'h96, aa, ad);
        `CHK({aa, ad}, 2'h3)
        `CHK({o7, o6, o1, o0}, 4'ha)
        `CHK(od_oe, 4'ha)
        `CHK(upper, 8'h3c)
    endtask
    task automatic pin_readback;
        logic [7:0] d;
        @(negedge clk) ext_lvl = 4'h1;
        read_one(ADR_LO, d);
        // released ports 4 read low from the pin although the latch is one
        `CHK(d, 8'h86)
        `CHK(flags, 4'h0)
    endtask
    task automatic transient_flag;
        logic [7:0] d;
        // port 3 is held low by the device, so its pulse never reaches a pin
        @(negedge clk) ext_lvl = 4'h7;
        repeat (10) @(negedge clk);
        ext_lvl = 4'h1;
        repeat (10) @(negedge clk);
        `CHK(flags, 4'h4)
        read_one(ADR_LO, d);
        `CHK(d, 8'h86)
        `CHK(flags, 4'h0)
    endtask
    task automatic bad_address;
        logic aa, ad;
        write_one(ADR_BAD, 8'h00, aa, ad);
        `CHK(aa, 1'b0)
        `CHK({o7, od_oe}, 5'h1a)
    endtask
    task automatic reset_abort;
        logic aa, ad, b;
        m.start_cond;
        m.write_byte({ADR_LO, 1'b1}, aa);
        m.recv_bit(b);
        `CHK({b, sda_oe}, 2'h3)
        @(negedge clk) rst_n = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(sda_oe, 1'b0)
        `CHK({upper, o7, od_oe}, 13'h1ff0)
        rst_n = 1'b1;
        m.stop_cond;
        write_one(ADR_UP, 8'h5a, aa, ad);
        `CHK({aa, ad, upper}, 10'h35a)
    endtask
    // straps are decoded afresh after each reset: supply, then data line
    task automatic strap_codes;
        logic aa, ad;
        @(negedge clk) rst_n = 1'b0;
        strap_lvl = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        write_one({expander_pkg::ADDR_UPPER, expander_pkg::STRAP_VDD,
                   expander_pkg::STRAP_SCL}, 8'h81, aa, ad);
        `CHK({aa, ad, upper}, 10'h381)
        @(negedge clk) rst_n = 1'b0;
        strap_sel = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        write_one({expander_pkg::ADDR_UPPER, expander_pkg::STRAP_SDA,
                   expander_pkg::STRAP_SCL}, 8'h42, aa, ad);
        `CHK({aa, ad, upper}, 10'h342)
    endtask
    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        strap_lvl  = 1'b0;
        strap_sel  = 1'b0;
        ext_lvl    = 4'hf;
        fail_count = 0;
        compares   = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        reset_values;
        upper_group;
        lower_group;
        pin_readback;
        transient_flag;
        bad_address;
        reset_abort;
        strap_codes;
        end_sim;
    end
    // the whole run needs about 10300 cycles
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim;
    end
endmodule // i2c_port_expander_16_tb
